// ### logic/sac_pkg.sv
package sac_pkg;

  // register offsets; printed offsets are not all multiples of four,
  // so they are word indices and the byte address is four times each
  localparam logic [15:0] SAC_IDX_PWRDN = 16'hfecb;
  localparam logic [15:0] SAC_IDX_RESULT = 16'hfecd;
  localparam logic [15:0] SAC_IDX_REFCFG = 16'hfed2;
  localparam logic [15:0] SAC_IDX_CTRL = 16'hfed6;
  localparam logic [15:0] SAC_IDX_IRQ_STAT = 16'hfed8;
  localparam logic [15:0] SAC_IDX_IRQ_MASK = 16'hfed9;

  // control word field positions
  localparam int SAC_CH_HI = 11;
  localparam int SAC_CH_LO = 8;
  localparam int SAC_START_BIT = 7;
  localparam int SAC_REPEAT_BIT = 6;
  localparam int SAC_DIV_HI = 5;

  // values after reset
  localparam logic [11:0] SAC_CTRL_RST = 12'h03f;
  localparam logic [15:0] SAC_ANA_RST = 16'h0000;
  localparam logic [9:0] SAC_RESULT_RST = 10'h000;

  // conversion clock: one half period is 16 x (divider + 1) clocks
  localparam logic [10:0] SAC_HALF_BASE = 11'h010;
  // falling converter clock edges per conversion (one per result bit)
  localparam logic [3:0] SAC_CONV_BITS = 4'ha;

  // conversion sequencer states, one-hot
  typedef enum logic [2:0] {
    SAC_IDLE = 3'b001,
    SAC_CONV = 3'b010,
    SAC_DONE = 3'b100
  } sac_state_t;

  // ahb-lite request as seen by the slave
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
  } sac_ahb_req_t;

  // link to the analog core
  typedef struct packed {
    logic [3:0] channel;
    logic conv_clk;
    logic sample;
  } sac_ana_t;

  // whole block state
  typedef struct packed {
    sac_state_t state;
    logic [11:0] ctrl;
    logic [15:0] pwrdn;
    logic [15:0] refcfg;
    logic [9:0] result;
    logic [3:0] chan_act;
    logic [10:0] div_cnt;
    logic conv_clk;
    logic [3:0] bit_cnt;
    logic sample;
    logic irq_stat;
    logic irq_mask;
    logic irq;
    logic dp_act;
    logic dp_write;
    logic [15:0] dp_idx;
    logic [31:0] rdata;
  } sac_st_t;

endpackage

// ### logic/sac_ctrl.sv
`timescale 1ns/100ps
// Function
// - setting start bit measures selected channel and stores 10-bit result
// - start bit clears itself when the result is ready in single mode (repeat bit 0)
// - interrupt raised each time result register updates
// - converter clock is input clock over 32 times divider plus one
// - repeat bit: 1 continuous, 0 single conversion per start
// - channel for each conversion comes from control bits 11:8
// - channel field copied only at start or while idle
// - continuous mode recopies channel field at end of each conversion
// - result is read-only 10 bits at its own address, zero after reset
module sac_ctrl
  import sac_pkg::*;
(
  input wire logic clk, // system clock, 100 MHz
  input wire logic rst_n, // synchronous reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic hready, // bus ready in
  input wire logic [31:0] hwdata, // write data
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // always ready
  output logic hresp, // always okay
  output logic irq, // level interrupt
  output logic [3:0] ana_channel, // channel to input multiplexer
  output logic ana_conv_clk, // converter clock
  output logic ana_sample, // pulse: core begins a conversion
  input wire logic [9:0] ana_result // result from analog core
);
  import sac_pkg::*;

  sac_st_t r, nx;
  sac_ahb_req_t req;
  logic [10:0] half;
  logic conv_edge;
  logic result_load;
  logic wr_stat;

  ////////////////////////////////////////////////////////////////////////
  // bus request bundle and helpers
  assign req = '{hsel, haddr, htrans, hwrite, hsize, hready};
  assign half = 11'(SAC_HALF_BASE * ({5'h00, r.ctrl[SAC_DIV_HI:0]} + 11'h001));
  assign conv_edge = (r.div_cnt == 11'(half - 11'h001));

  ////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    nx = r;
    result_load = 1'b0;
    wr_stat = 1'b0;
    nx.sample = 1'b0;

    // address phase capture
    nx.dp_act = req.hsel && req.hready && req.htrans[1];
    nx.dp_write = req.hwrite;
    nx.dp_idx = req.haddr[17:2];

    // data phase write
    if (r.dp_act && r.dp_write) begin
      case (r.dp_idx)
        SAC_IDX_CTRL: nx.ctrl = hwdata[11:0];
        SAC_IDX_PWRDN: nx.pwrdn = hwdata[15:0];
        SAC_IDX_REFCFG: nx.refcfg = hwdata[15:0];
        SAC_IDX_IRQ_MASK: nx.irq_mask = hwdata[0];
        SAC_IDX_IRQ_STAT: wr_stat = hwdata[0];
        default: ;
      endcase
    end

    // divider runs only while converting
    if (r.state == SAC_CONV) begin
      if (conv_edge) begin
        nx.div_cnt = 11'h000;
        nx.conv_clk = ~r.conv_clk;
      end else begin
        nx.div_cnt = 11'(r.div_cnt + 11'h001);
      end
    end else begin
      nx.div_cnt = 11'h000;
      nx.conv_clk = 1'b0;
    end

    // sequencer
    case (r.state)
      SAC_IDLE: begin
        nx.chan_act = r.ctrl[SAC_CH_HI:SAC_CH_LO];
        if (r.ctrl[SAC_START_BIT]) begin
          nx.state = SAC_CONV;
          nx.bit_cnt = 4'h0;
          nx.sample = 1'b1;
        end
      end
      SAC_CONV: begin
        // count falling converter clock edges, one per bit
        if (conv_edge && r.conv_clk) begin
          if (r.bit_cnt == SAC_CONV_BITS - 4'h1) begin
            nx.state = SAC_DONE;
          end else begin
            nx.bit_cnt = 4'(r.bit_cnt + 4'h1);
          end
        end
      end
      SAC_DONE: begin
        result_load = 1'b1;
        nx.result = ana_result;
        if (r.ctrl[SAC_REPEAT_BIT] && r.ctrl[SAC_START_BIT]) begin
          nx.chan_act = r.ctrl[SAC_CH_HI:SAC_CH_LO];
          nx.state = SAC_CONV;
          nx.bit_cnt = 4'h0;
          nx.sample = 1'b1;
        end else begin
          nx.state = SAC_IDLE;
        end
      end
      default: nx.state = SAC_IDLE;
    endcase

    // start bit self-clears in single mode on the same edge the result is stored
    if (result_load && !r.ctrl[SAC_REPEAT_BIT]) begin
      nx.ctrl[SAC_START_BIT] = 1'b0;
    end

    // sticky status: set wins over clear
    if (wr_stat) begin
      nx.irq_stat = 1'b0;
    end
    if (result_load) begin
      nx.irq_stat = 1'b1;
    end
    nx.irq = nx.irq_stat && nx.irq_mask;

    // read data for next data phase
    nx.rdata = 32'h0000_0000;
    if (req.hsel && req.hready && req.htrans[1] && !req.hwrite) begin
      case (req.haddr[17:2])
        SAC_IDX_CTRL: nx.rdata = {20'h0_0000, nx.ctrl};
        SAC_IDX_RESULT: nx.rdata = {22'h00_0000, nx.result};
        SAC_IDX_PWRDN: nx.rdata = {16'h0000, nx.pwrdn};
        SAC_IDX_REFCFG: nx.rdata = {16'h0000, nx.refcfg};
        SAC_IDX_IRQ_STAT: nx.rdata = {31'h0000_0000, nx.irq_stat};
        SAC_IDX_IRQ_MASK: nx.rdata = {31'h0000_0000, nx.irq_mask};
        default: nx.rdata = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '{state: SAC_IDLE, ctrl: SAC_CTRL_RST, pwrdn: SAC_ANA_RST,
             refcfg: SAC_ANA_RST, result: SAC_RESULT_RST, default: '0};
    end else begin
      r <= nx;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from flip-flops, bus ready and response tied to constants
  assign hrdata = r.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = r.irq;
  assign ana_channel = r.chan_act;
  assign ana_conv_clk = r.conv_clk;
  assign ana_sample = r.sample;

endmodule

// ### test/sac_core_model.sv
`timescale 1ns/100ps
module sac_core_model (
  input wire logic clk, // clock
  input wire logic ana_sample, // start
  input wire logic [3:0] ana_channel, // channel
  output logic [9:0] ana_result // code
);
  logic [3:0] ch_r;
  logic [9:0] n_r = 10'h3ff;
  // latch channel at start, count clocks since
  always @(posedge clk) begin
    n_r <= ana_sample ? 10'h000 : n_r + 10'(n_r != 10'h3ff);
    if (ana_sample) ch_r <= ana_channel;
  end
  // code is inverted before it settles
  assign ana_result = n_r > 10'h12c ? {ch_r, 6'h2b} : ~{ch_r, 6'h2b};
endmodule

// ### test/sac_ctrl_asserts.sv
`timescale 1ns/100ps
module sac_ctrl_asserts
  import sac_pkg::*;
(
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire logic [31:0] haddr, // addr
  input wire logic [1:0] htrans, // type
  input wire logic hwrite, // dir
  input wire logic [31:0] hrdata, // rdata
  input wire logic hreadyout, // ready
  input wire logic hresp, // resp
  input wire logic irq, // irq
  input wire logic [3:0] ana_channel, // chan
  input wire logic ana_conv_clk, // cclk
  input wire logic ana_sample // start
);
  logic rd_r;
  logic [15:0] ad_r;
  logic [11:0] hi_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // read phase and conv clock high time
  always_ff @(posedge clk) begin
    rd_r <= htrans[1] && !hwrite;
    ad_r <= haddr[17:2];
    hi_r <= ana_conv_clk ? hi_r + 12'h001 : 12'h000;
  end
  bus_ready_a: assert property (hreadyout && !hresp)
    else $error("bus stall");
  start_pulse_a: assert property (ana_sample |=> !ana_sample[*8])
    else $error("start pulse");
  chan_hold_a: assert property (ana_conv_clk |-> $stable(ana_channel))
    else $error("channel moved");
  high_min_a: assert property ($rose(ana_conv_clk) |=> ana_conv_clk[*8])
    else $error("short high");
  half_len_a: assert property ($fell(ana_conv_clk) |->
    hi_r[3:0] == 4'h0 && hi_r != 12'h000) else $error("half period");
  res_width_a: assert property (rd_r && ad_r == SAC_IDX_RESULT |->
    hrdata[31:10] == 22'h0) else $error("result width");
  ctl_width_a: assert property (rd_r && ad_r == SAC_IDX_CTRL |->
    hrdata[31:12] == 20'h0) else $error("control width");
  rst_quiet_a: assert property (!$past(rst_n) |-> !irq && !ana_sample)
    else $error("reset value");
  cover property ($rose(irq));
  cover property ($fell(ana_conv_clk) && hi_r == 12'h020);
  cover property (ana_sample && ana_channel == 4'h7);
endmodule
bind sac_ctrl sac_ctrl_asserts chk_u (.*);

// ### test/tb_sac_ctrl.sv
`timescale 1ns/100ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin \
  err_count++; $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module tb_sac_ctrl;
  import sac_pkg::*;
  logic clk = '0, rst_n = '0, hsel = 1'b1, hwrite = '0, dp = '0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, ex;
  logic [1:0] htrans = '0;
  logic hreadyout, hresp, irq, ana_sample, ana_conv_clk;
  logic [3:0] ana_channel, ch;
  logic [9:0] ana_result;
  logic [7:0] lf = 8'h04;
  logic [31:0] q[$];
  int err_count = 0, checks_done = 0;
  logic [3:0] cd [9] = '{4'hc, 4'ha, 4'h8, 4'h7, 4'h6,
    4'h5, 4'h4, 4'h2, 4'h0};
  always #5 clk = ~clk;
  sac_ctrl dut_u (.hready(hreadyout), .hsize(3'b010), .*);
  sac_core_model core_u (.*);
  function logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // one word transfer; a read notes its expected data
  task bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    if (!w) q.push_back(d);
    haddr <= {14'h0, a, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (!hreadyout);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (!hreadyout);
  endtask
  // look at irq off the launching edge, then realign to a rising edge
  task wi(input logic v);
    @(negedge clk);
    for (int n = 0; n < 2000 && irq !== v; n++) @(negedge clk);
    `CHK("irq", v, irq)
    @(posedge clk);
  endtask
  task finish_test;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // compare each read data phase with the oldest note
  always @(posedge clk) begin
    if (dp) begin
      ex = q.pop_front();
      `CHK("hrdata", ex, hrdata)
    end
    dp <= htrans[1] && !hwrite;
  end
  // hang guard
  initial begin
    #200000;
    err_count++;
    finish_test;
  end
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(0, SAC_IDX_CTRL, 32'h3f);
    bus(0, SAC_IDX_RESULT, 32'h0);
    bus(0, 16'h0, 32'h0);
    bus(1, SAC_IDX_REFCFG, 32'h8000);
    bus(1, SAC_IDX_PWRDN, 32'h0100);
    bus(0, SAC_IDX_PWRDN, 32'h0100);
    bus(1, SAC_IDX_IRQ_MASK, 32'h1);
    repeat (9) begin
      lf = lfsr(lf);
      ch = cd[lf % 9];
      bus(1, SAC_IDX_CTRL, {20'h0, ch, 8'h80});
      wi(1);
      bus(0, SAC_IDX_RESULT, {22'h0, ch, 6'h2b});
      bus(0, SAC_IDX_CTRL, {20'h0, ch, 8'h00});
      bus(1, SAC_IDX_IRQ_STAT, 32'h1);
    end
    bus(1, SAC_IDX_CTRL, 32'hcc1);
    bus(1, SAC_IDX_CTRL, 32'h7c1);
    wi(1);
    bus(0, SAC_IDX_RESULT, 32'h32b);
    bus(1, SAC_IDX_IRQ_STAT, 32'h1);
    wi(1);
    bus(0, SAC_IDX_RESULT, 32'h1eb);
    bus(0, SAC_IDX_CTRL, 32'h7c1);
    bus(1, SAC_IDX_IRQ_MASK, 32'h0);
    wi(0);
    bus(1, SAC_IDX_IRQ_MASK, 32'h1);
    wi(1);
    finish_test;
  end
endmodule
